/* File: pkg/bmt_pkg.sv */
`default_nettype none

package bmt_pkg;

  // Addressing forms of the byte move group
  typedef enum logic [4:0] {
    BMT_R_IMM, BMT_STW_IMM, BMT_CS_IMM, BMT_XSEG_IMM,
    BMT_ABS_IMM, BMT_XSEG_ABS_IMM, BMT_SADDR_IMM, BMT_SFR_IMM,
    BMT_PTR_IMM, BMT_XSEG_PTR_IMM, BMT_SP_IMM, BMT_IDX_IMM,
    BMT_XSEG_IDX_IMM, BMT_A_R, BMT_R_A, BMT_A_STW, BMT_STW_A,
    BMT_A_CS, BMT_CS_A, BMT_A_XSEG, BMT_XSEG_A, BMT_A_ABS,
    BMT_A_XSEG_ABS, BMT_ABS_A, BMT_XSEG_ABS_A, BMT_A_SADDR,
    BMT_SADDR_A
  } bmt_form_t;

  // Memory area an operand or a fetch touches
  typedef enum logic [1:0] {
    BMT_AREA_RAM, BMT_AREA_SFR, BMT_AREA_FLASH, BMT_AREA_NONE
  } bmt_area_t;

  // Request from the fetch unit
  typedef struct packed {
    bmt_form_t   form;
    logic [2:0]  reg_sel;
    bmt_area_t   data_area;
    logic        fetch_ram;
    logic [7:0]  imm;
  } bmt_req_t;

  // Decoded answer to the datapath
  typedef struct packed {
    logic [2:0]  length;
    logic [3:0]  clocks;
    logic        illegal;
    logic        stw_wr;
    logic [7:0]  stw_val;
  } bmt_rsp_t;

  localparam logic [2:0] BMT_REG_A          = 3'h1;
  localparam logic [3:0] BMT_FLASH_CLK      = 4'h4;
  localparam logic [3:0] BMT_FLASH_XSEG_CLK = 4'h5;
  localparam logic [3:0] BMT_STW_CLK        = 4'h3;
  localparam logic [3:0] BMT_RAM_EXTRA      = 4'h3;
  localparam int         BMT_ZERO_BIT       = 6;
  localparam int         BMT_AUX_BIT        = 4;
  localparam int         BMT_CARRY_BIT      = 0;
  localparam logic [7:0] BMT_STW_RST        = 8'h06;

endpackage : bmt_pkg

`default_nettype wire

/* File: hw/bmt_decode.sv */
`timescale 1ns/100ps
`default_nettype none

// Operation
// RULE1: Listed counts hold for RAM, SFR, extended SFR or no data access.
// RULE2: Absolute load from flash takes 4 clocks, 5 in the segment form.
// RULE3: A RAM fetch doubles the count and adds up to 3 clocks.
// RULE4: Register-accumulator moves are 1 byte, 1 clock, never from A.
// RULE5: Immediate to status word is 3 bytes, 3 clocks, sets Z, aux, carry.
// RULE6: Immediate to extra segment register is 2 bytes and 1 clock.
// RULE7: Immediate to absolute address is 4 bytes and 1 clock.
// RULE8: Segment form of that store is 5 bytes and 2 clocks.
// RULE9: Immediate to pointer plus displacement is 3 bytes and 1 clock.
// RULE10: Immediate to word base indexed by a register is 4 bytes, 1 clock.
// RULE11: Accumulator to short direct address is 2 bytes and 1 clock.
// RULE12: Moves not aimed at the status word keep Z, aux and carry.
module bmt_decode
  import bmt_pkg::*;
(
  input  wire logic     clk_sys,   // CPU clock, 250 MHz
  input  wire logic     rstn,      // Async reset, active low
  input  wire logic     req_valid, // Instruction offered
  input  wire bmt_req_t req,       // Decoded form and context
  output logic          rsp_valid, // Answer valid, one cycle
  output bmt_rsp_t      rsp,       // Length, clocks, flags
  output logic [7:0]    stw_q      // Program status word
);

  bmt_rsp_t   rsp_d;       // Answer for the offered form
  bmt_rsp_t   rsp_q;       // Answer register
  logic       rsp_valid_q; // Answer strobe register
  logic [7:0] stw_d;       // Status word after a write
  logic [3:0] base_clk;    // Count for a fetch from flash
  logic       is_src_a;    // Register field names the accumulator

  // Only A,r and r,A look at this; other forms ignore the field
  assign is_src_a = (req.reg_sel == BMT_REG_A);

  // Length and listed count per form; spare codes come out illegal
  always_comb
  begin
    rsp_d         = '0;
    base_clk      = 4'h1;
    rsp_d.stw_val = req.imm;
    unique case (req.form)
      // RULE6: segment immediate
      BMT_XSEG_IMM:
        rsp_d.length = 3'd2;
      // Other two-byte, one-clock moves
      BMT_R_IMM, BMT_A_STW, BMT_A_CS, BMT_CS_A, BMT_A_XSEG,
      BMT_XSEG_A, BMT_A_SADDR:
        rsp_d.length = 3'd2;
      // RULE11: short direct store
      BMT_SADDR_A:
        rsp_d.length = 3'd2;
      // RULE5: status word immediate
      BMT_STW_IMM:
      begin
        rsp_d.length = 3'd3;
        base_clk     = BMT_STW_CLK;
        rsp_d.stw_wr = 1'b1;
      end
      // Status word from the accumulator writes the flags too
      BMT_STW_A:
      begin
        rsp_d.length = 3'd2;
        base_clk     = BMT_STW_CLK;
        rsp_d.stw_wr = 1'b1;
      end
      // RULE9: pointer plus displacement
      BMT_PTR_IMM:
        rsp_d.length = 3'd3;
      // Other three-byte, one-clock moves
      BMT_CS_IMM, BMT_SADDR_IMM, BMT_SFR_IMM, BMT_SP_IMM, BMT_ABS_A:
        rsp_d.length = 3'd3;
      // RULE7: absolute store
      BMT_ABS_IMM:
        rsp_d.length = 3'd4;
      // RULE10: indexed store
      BMT_IDX_IMM:
        rsp_d.length = 3'd4;
      // Segment pointer store and segment absolute store from A
      BMT_XSEG_PTR_IMM, BMT_XSEG_ABS_A:
      begin
        rsp_d.length = 3'd4;
        base_clk     = 4'h2;
      end
      // RULE8: one byte and one clock more
      BMT_XSEG_ABS_IMM, BMT_XSEG_IDX_IMM:
      begin
        rsp_d.length = 3'd5;
        base_clk     = 4'h2;
      end
      // RULE4: register moves reject the accumulator
      BMT_A_R, BMT_R_A:
      begin
        rsp_d.length  = 3'd1;
        rsp_d.illegal = is_src_a;
      end
      // RULE1: RULE2: flash operand costs more
      BMT_A_ABS:
      begin
        rsp_d.length = 3'd3;
        base_clk = (req.data_area == BMT_AREA_FLASH) ? BMT_FLASH_CLK : 4'h1;
      end
      // RULE2: segment form from flash
      BMT_A_XSEG_ABS:
      begin
        rsp_d.length = 3'd4;
        base_clk = (req.data_area == BMT_AREA_FLASH) ? BMT_FLASH_XSEG_CLK
                                                     : 4'h2;
      end
      // Spare codes of the five-bit form field
      default:
        rsp_d.illegal = 1'b1;
    endcase
    // RULE3: RAM fetch doubled
    // Reported as the worst case; the core may finish up to 3 earlier
    if (req.fetch_ram)
      rsp_d.clocks = 4'((base_clk << 1) + BMT_RAM_EXTRA);
    else
      rsp_d.clocks = base_clk;
    // An illegal move must never touch the flags
    if (rsp_d.illegal)
      rsp_d.stw_wr = 1'b0;
  end

  // Answer register, one cycle after the request
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rsp_q       <= '0;
      rsp_valid_q <= 1'b0;
    end
    else
    begin
      rsp_valid_q <= req_valid;
      if (req_valid)
        rsp_q <= rsp_d;
    end
  end

  // Only Z, aux and carry follow the written byte; the rest is kept
  always_comb
  begin
    stw_d = stw_q;
    stw_d[BMT_ZERO_BIT]  = rsp_d.stw_val[BMT_ZERO_BIT];
    stw_d[BMT_AUX_BIT]   = rsp_d.stw_val[BMT_AUX_BIT];
    stw_d[BMT_CARRY_BIT] = rsp_d.stw_val[BMT_CARRY_BIT];
  end

  // RULE5: RULE12: status word writes only
  // Updated at the taking edge, so flags and answer appear together
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      stw_q <= BMT_STW_RST;
    else if (req_valid && rsp_d.stw_wr)
      stw_q <= stw_d;
  end

  // Outputs straight from the answer flip-flops
  assign rsp_valid = rsp_valid_q;
  assign rsp       = rsp_q;

  // Assertions
  stw_hold_a: assert property ( // RULE12
    @(posedge clk_sys) disable iff (!rstn)
    (req_valid && !rsp_d.stw_wr) |=> $stable(stw_q))
    else $error("status word changed without write");

  stw_load_a: assert property ( // RULE5
    @(posedge clk_sys) disable iff (!rstn)
    (req_valid && req.form == BMT_STW_IMM && !req.fetch_ram)
    |=> rsp.length == 3'd3 && rsp.clocks == 4'h3
        && stw_q[BMT_CARRY_BIT] == $past(req.imm[BMT_CARRY_BIT]))
    else $error("status word immediate wrong");

  flash_abs_a: assert property ( // RULE2
    @(posedge clk_sys) disable iff (!rstn)
    (req_valid && req.form == BMT_A_ABS && !req.fetch_ram
     && req.data_area == BMT_AREA_FLASH) |=> rsp.clocks == 4'h4)
    else $error("flash absolute load not 4 clocks");

  flash_seg_a: assert property ( // RULE2
    @(posedge clk_sys) disable iff (!rstn)
    (req_valid && req.form == BMT_A_XSEG_ABS && !req.fetch_ram
     && req.data_area == BMT_AREA_FLASH) |=> rsp.clocks == 4'h5)
    else $error("flash segment load not 5 clocks");

  ram_abs_a: assert property ( // RULE1
    @(posedge clk_sys) disable iff (!rstn)
    (req_valid && req.form == BMT_A_ABS && !req.fetch_ram
     && req.data_area != BMT_AREA_FLASH) |=> rsp.clocks == 4'h1)
    else $error("internal area load not 1 clock");

  ram_fetch_a: assert property ( // RULE3
    @(posedge clk_sys) disable iff (!rstn)
    (req_valid && req.form == BMT_ABS_IMM && req.fetch_ram)
    |=> rsp.clocks == 4'h5)
    else $error("RAM fetch count wrong");

  acc_reject_a: assert property ( // RULE4
    @(posedge clk_sys) disable iff (!rstn)
    (req_valid && req.form == BMT_A_R)
    |=> rsp.illegal == $past(is_src_a) && rsp.length == 3'd1)
    else $error("accumulator move check wrong");

  seg_imm_a: assert property ( // RULE6
    @(posedge clk_sys) disable iff (!rstn)
    (req_valid && req.form == BMT_XSEG_IMM && !req.fetch_ram)
    |=> rsp.length == 3'd2 && rsp.clocks == 4'h1)
    else $error("segment immediate wrong");

  seg_abs_imm_a: assert property ( // RULE8
    @(posedge clk_sys) disable iff (!rstn)
    (req_valid && req.form == BMT_XSEG_ABS_IMM && !req.fetch_ram)
    |=> rsp.length == 3'd5 && rsp.clocks == 4'h2)
    else $error("segment absolute store wrong");

  idx_imm_a: assert property ( // RULE7 RULE10
    @(posedge clk_sys) disable iff (!rstn)
    (req_valid && (req.form == BMT_IDX_IMM || req.form == BMT_ABS_IMM)
     && !req.fetch_ram) |=> rsp.length == 3'd4 && rsp.clocks == 4'h1)
    else $error("absolute or indexed store wrong");

  ptr_imm_a: assert property ( // RULE9
    @(posedge clk_sys) disable iff (!rstn)
    (req_valid && req.form == BMT_PTR_IMM && !req.fetch_ram)
    |=> rsp.length == 3'd3 && rsp.clocks == 4'h1)
    else $error("pointer store wrong");

  saddr_a: assert property ( // RULE11
    @(posedge clk_sys) disable iff (!rstn)
    (req_valid && req.form == BMT_SADDR_A && !req.fetch_ram)
    |=> rsp.length == 3'd2 && rsp.clocks == 4'h1)
    else $error("short direct store wrong");

  stw_from_a_a: assert property ( // RULE12
    @(posedge clk_sys) disable iff (!rstn)
    (req_valid && req.form == BMT_STW_A && !req.fetch_ram)
    |=> rsp.length == 3'd2 && rsp.clocks == 4'h3 && rsp.stw_wr)
    else $error("status word from accumulator wrong");

  rsp_strobe_a: assert property ( // RULE1
    @(posedge clk_sys) disable iff (!rstn)
    req_valid |=> rsp_valid)
    else $error("answer strobe missing");

  spare_code_a: assert property ( // RULE4
    @(posedge clk_sys) disable iff (!rstn)
    (req_valid && req.form > BMT_SADDR_A)
    |=> rsp.illegal && !rsp.stw_wr)
    else $error("spare form code accepted");

endmodule : bmt_decode

`default_nettype wire

/* File: tb/bmt_fetch_model.sv */
`timescale 1ns/100ps
`default_nettype none

module bmt_fetch_model
  import bmt_pkg::*;
(
  input  wire logic     clk_sys,   // CPU clock
  input  wire logic     rstn,      // Async reset, active low
  input  wire logic     cmd_go,    // Bench asks for one move
  input  wire bmt_req_t cmd_req,   // Move to offer
  output logic          req_valid, // Offered to decoder
  output bmt_req_t      req        // Move fields
);
  // Offer one cycle later; idle fields toggle so stale data is never reused
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      req_valid <= 1'b0;
      req       <= '0;
    end
    else
    begin
      req_valid <= #1 cmd_go;
      req       <= #1 (cmd_go ? cmd_req : ~req);
    end
  end
endmodule : bmt_fetch_model

`default_nettype wire

/* File: tb/byte_move_length_timing_bench.sv */
`timescale 1ns/100ps
`default_nettype none

module byte_move_length_timing_bench;
  import bmt_pkg::*;
  localparam logic [7:0] FLG = 8'((1 << BMT_ZERO_BIT) | (1 << BMT_AUX_BIT)
                                  | (1 << BMT_CARRY_BIT));
  localparam bmt_form_t  SPARE = bmt_form_t'(5'h1E);
  logic       clk_sys = 1'b0;
  logic       rstn;
  logic       cmd_go;
  bmt_req_t   cmd_req;
  logic       req_valid;
  bmt_req_t   req;
  logic       rsp_valid;
  bmt_rsp_t   rsp;
  logic [7:0] stw_q;
  logic [7:0] stw_exp;
  int         failures = 0;
  int         cmp_count = 0;
  int         cycles = 0;

  always #2 clk_sys = ~clk_sys;

  bmt_fetch_model i_fetch (.clk_sys(clk_sys), .rstn(rstn), .cmd_go(cmd_go),
    .cmd_req(cmd_req), .req_valid(req_valid), .req(req));
  bmt_decode i_dut (.clk_sys(clk_sys), .rstn(rstn), .req_valid(req_valid),
    .req(req), .rsp_valid(rsp_valid), .rsp(rsp), .stw_q(stw_q));

  function automatic bmt_req_t rq(input bmt_form_t f,
    input bmt_area_t a = BMT_AREA_RAM, input logic fr = 1'b0,
    input logic [2:0] rs = 3'h0, input logic [7:0] imm = 8'h00);
    return '{f, rs, a, fr, imm};
  endfunction : rq

  task automatic cmp(input string what, input logic [7:0] got,
                     input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // Judge the answer 1 ns after the taking edge; flags tracked alongside
  task automatic chk(input bmt_req_t r, input logic [2:0] len,
                     input logic [3:0] clk);
    logic bad;
    logic pw;
    bad = ((r.form inside {BMT_A_R, BMT_R_A}) && r.reg_sel == BMT_REG_A)
          || r.form == SPARE;
    pw = !bad && (r.form inside {BMT_STW_IMM, BMT_STW_A});
    if (pw)
      stw_exp = (stw_exp & ~FLG) | (r.imm & FLG);
    cmp("valid", 8'(rsp_valid), 8'h01);
    cmp("illegal", 8'(rsp.illegal), 8'(bad));
    cmp("stw_wr", 8'(rsp.stw_wr), 8'(pw));
    cmp("stw_val", rsp.stw_val, r.imm);
    cmp("status", stw_q, stw_exp);
    if (!bad)
    begin
      cmp("length", 8'(rsp.length), 8'(len));
      cmp("clocks", 8'(rsp.clocks), 8'(clk));
    end
  endtask : chk

  task automatic mv(input bmt_req_t r, input logic [2:0] len,
                    input logic [3:0] clk);
    cmd_req = r;
    cmd_go = 1'b1;
    @(posedge clk_sys) #1 cmd_go = 1'b0;
    @(posedge clk_sys) #1 chk(r, len, clk);
  endtask : mv

  // Length and listed clocks of each form except A,abs and its segment form, which t_timing covers, and r,A, driven only with the accumulator
  task automatic t_forms;
    mv(rq(BMT_STW_IMM, BMT_AREA_NONE, 1'b0, 3'h0, 8'hAA), 3'h3, 4'h3);
    mv(rq(BMT_STW_A, BMT_AREA_NONE, 1'b0, 3'h0, 8'h11), 3'h2, 4'h3);
    mv(rq(BMT_XSEG_IMM), 3'h2, 4'h1);
    mv(rq(BMT_ABS_IMM), 3'h4, 4'h1);
    mv(rq(BMT_XSEG_ABS_IMM), 3'h5, 4'h2);
    mv(rq(BMT_XSEG_IDX_IMM), 3'h5, 4'h2);
    mv(rq(BMT_XSEG_PTR_IMM), 3'h4, 4'h2);
    mv(rq(BMT_XSEG_ABS_A), 3'h4, 4'h2);
    mv(rq(BMT_R_IMM, BMT_AREA_NONE), 3'h2, 4'h1);
    mv(rq(BMT_CS_IMM, BMT_AREA_SFR), 3'h3, 4'h1);
    mv(rq(BMT_SADDR_IMM), 3'h3, 4'h1);
    mv(rq(BMT_SFR_IMM, BMT_AREA_SFR), 3'h3, 4'h1);
    mv(rq(BMT_SP_IMM), 3'h3, 4'h1);
    mv(rq(BMT_ABS_A), 3'h3, 4'h1);
    mv(rq(BMT_A_STW, BMT_AREA_NONE), 3'h2, 4'h1);
    mv(rq(BMT_A_CS, BMT_AREA_NONE), 3'h2, 4'h1);
    mv(rq(BMT_CS_A, BMT_AREA_NONE), 3'h2, 4'h1);
    mv(rq(BMT_A_XSEG, BMT_AREA_NONE), 3'h2, 4'h1);
    mv(rq(BMT_XSEG_A, BMT_AREA_NONE), 3'h2, 4'h1);
    mv(rq(BMT_A_SADDR), 3'h2, 4'h1);
    mv(rq(SPARE, BMT_AREA_NONE, 1'b0, 3'h0, 8'hFF), 3'h0, 4'h0);
    mv(rq(BMT_PTR_IMM), 3'h3, 4'h1);
    mv(rq(BMT_IDX_IMM, BMT_AREA_SFR), 3'h4, 4'h1);
    mv(rq(BMT_SADDR_A), 3'h2, 4'h1);
    mv(rq(BMT_A_R, BMT_AREA_NONE, 1'b0, 3'h2), 3'h1, 4'h1);
    mv(rq(BMT_A_R, BMT_AREA_NONE, 1'b0, BMT_REG_A), 3'h1, 4'h1);
    mv(rq(BMT_R_A, BMT_AREA_NONE, 1'b0, BMT_REG_A), 3'h1, 4'h1);
  endtask : t_forms

  // Data area and fetch source stretch the count
  task automatic t_timing;
    mv(rq(BMT_A_ABS, BMT_AREA_SFR), 3'h3, 4'h1);
    mv(rq(BMT_A_ABS, BMT_AREA_FLASH), 3'h3, BMT_FLASH_CLK);
    mv(rq(BMT_A_XSEG_ABS, BMT_AREA_FLASH), 3'h4, 4'h5);
    mv(rq(BMT_A_XSEG_ABS, BMT_AREA_RAM), 3'h4, 4'h2);
    mv(rq(BMT_XSEG_ABS_IMM, BMT_AREA_RAM, 1'b1), 3'h5, 4'h7);
    mv(rq(BMT_A_R, BMT_AREA_NONE, 1'b1, 3'h3), 3'h1, 4'h5);
  endtask : t_timing

  // Back to back: flags all set, then a plain store must leave them
  task automatic t_back;
    bmt_req_t p;
    p = rq(BMT_STW_IMM, BMT_AREA_NONE, 1'b0, 3'h0, 8'hFF);
    cmd_req = p;
    cmd_go = 1'b1;
    @(posedge clk_sys) #1 cmd_req = rq(BMT_ABS_IMM);
    @(posedge clk_sys) #1 cmd_go = 1'b0;
    chk(p, 3'h3, 4'h3);
    @(posedge clk_sys) #1 chk(rq(BMT_ABS_IMM), 3'h4, 4'h1);
  endtask : t_back

  // Reset in mid-run puts the status word back and drops the strobe
  task automatic t_reset;
    mv(rq(BMT_STW_IMM, BMT_AREA_NONE, 1'b0, 3'h0, 8'h51), 3'h3, 4'h3);
    rstn = 1'b0;
    #1 cmp("reset status", stw_q, BMT_STW_RST);
    cmp("reset valid", 8'(rsp_valid), 8'h00);
    stw_exp = BMT_STW_RST;
    repeat (3) @(posedge clk_sys);
    #1 rstn = 1'b1;
    mv(rq(BMT_A_SADDR), 3'h2, 4'h1);
  endtask : t_reset

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  // Hang guard, far above the 86 cycles needed
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      failures++;
      close_out();
    end
  end

  initial
  begin
    rstn = 1'b0;
    cmd_go = 1'b0;
    cmd_req = '0;
    stw_exp = BMT_STW_RST;
    repeat (10) @(posedge clk_sys);
    #1 rstn = 1'b1;
    cmp("status", stw_q, BMT_STW_RST);
    t_forms();
    t_timing();
    t_back();
    t_reset();
    close_out();
  end
endmodule : byte_move_length_timing_bench

`default_nettype wire
